// ---- rtl/civ_core.sv ----
// Purpose: core interrupt vectoring and acknowledge logic
// Assumes: sequencer gives instrDone and rtiExec pulses
// Notes:   registers on AXI4-Lite; one nesting level only
// Functional notes
// - on interrupt, let current instruction finish, then branch to its vector slot
// - return-from-interrupt ends service and resumes interrupted flow
// - non-arithmetic sources acknowledged by the return alone
// - arithmetic exceptions re-raise until status bit cleared, then return
// - core priorities hard-wired, not software alterable
// - priority falls with number; 0 highest, 41 lowest; 38-41 software raised
// - vector is 48-bit base plus four times the number
// - number 2 on illegal peripheral or unaligned long-word access
// - number 3 on stack overflow or program-counter stack full
// - timer expiry raises both number 4 and number 32
// - circular buffer overflows raise numbers 30 and 31
// - low emulator interrupt is number 37
// - slots 11 to 29 take peripheral sources; others are fixed
// - arithmetic exceptions take numbers 33 to 36
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module civ_core
   import civ_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // core event sources
   input  wire logic        emulator_high_irq,
   input  wire logic        reset_irq,
   input  wire logic        illegal_access_irq,
   input  wire logic        stack_overflow_irq,
   input  wire logic        timer_expiry,
   input  wire logic        serial_port_error_irq,
   input  wire logic        hardware_breakpoint_irq,
   input  wire logic [2:0]  external_request_irq,
   input  wire logic [18:0] programmable_irq,
   input  wire logic        circ_buf_seven_irq,
   input  wire logic        circ_buf_fifteen_irq,
   input  wire logic [3:0]  arith_status,
   input  wire logic        emulator_low_irq,
   // sequencer
   input  wire logic        instrDone,
   input  wire logic        rtiExec,
   output logic             vecBranch,
   output logic [47:0]      vecAddr,
   output logic [5:0]       vecNum,
   output logic             inService,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction

   logic [41:0]  latch_ff, nxt_latch;
   logic [41:0]  mask_ff, nxt_mask;
   logic [47:0]  base_ff, nxt_base;
   logic         enable_ff, nxt_enable;
   civ_state_t   state_ff, nxt_state;
   logic [5:0]   num_ff, nxt_num;
   logic         branch_ff, nxt_branch;
   logic [47:0]  addr_ff, nxt_addr;
   logic         irq_ff, nxt_irq;
   logic         awHave_ff, nxt_awHave, wHave_ff, nxt_wHave;
   logic [7:0]   awAddr_ff, nxt_awAddr;
   logic [31:0]  wData_ff, nxt_wData;
   logic [3:0]   wStrb_ff, nxt_wStrb;
   logic         bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0]   bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0]  rdata_ff, nxt_rdata;
   logic [41:0]  srcVec, pendReq, softSet;
   logic         winAny;
   logic [5:0]   winNum;
   logic         doWrite;
   logic [63:0]  wideLatch, wideMask;

   // fixed wiring of sources to slots
   always_comb begin
      srcVec                    = '0;
      srcVec[SRC_EMU_HIGH]      = emulator_high_irq;
      srcVec[SRC_RESET]         = reset_irq;
      srcVec[SRC_ILLEGAL]       = illegal_access_irq;
      srcVec[SRC_STACK_OVF]     = stack_overflow_irq;
      srcVec[SRC_TMR_HIGH]      = timer_expiry;
      srcVec[5]                 = serial_port_error_irq;
      srcVec[6]                 = hardware_breakpoint_irq;
      srcVec[SRC_RESERVED]      = 1'b0;
      srcVec[10:8]              = {external_request_irq[0], external_request_irq[1],
                                   external_request_irq[2]};
      srcVec[SRC_PROG_HI:SRC_PROG_LO] = programmable_irq;
      srcVec[SRC_CB_SEVEN]      = circ_buf_seven_irq;
      srcVec[SRC_CB_FIFTN]      = circ_buf_fifteen_irq;
      srcVec[SRC_TMR_LOW]       = timer_expiry;
      // level, not edge: keeps firing while the status bit stays set
      srcVec[SRC_FLT_INV:SRC_FIX_OVF] = arith_status;
      srcVec[SRC_EMU_LOW]       = emulator_low_irq;
   end

   assign pendReq = latch_ff & mask_ff;
   civ_prio_enc #(.N(CIV_NSRC)) u_prio (
      .req (pendReq),
      .any (winAny),
      .num (winNum)
   );
   assign doWrite   = awHave_ff & wHave_ff & ~bvalid_ff;
   assign wideLatch = {22'h0, latch_ff};
   assign wideMask  = {22'h0, mask_ff};
   // bus slave
   always_comb begin
      nxt_awHave = awHave_ff;
      nxt_awAddr = awAddr_ff;
      nxt_wHave  = wHave_ff;
      nxt_wData  = wData_ff;
      nxt_wStrb  = wStrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp  = rresp_ff;
      nxt_rdata  = rdata_ff;
      if (s_axi_awvalid && !awHave_ff) begin
         nxt_awHave = 1'b1;
         nxt_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_ff) begin
         nxt_wHave = 1'b1;
         nxt_wData = s_axi_wdata;
         nxt_wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         nxt_awHave = 1'b0;
         nxt_wHave  = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = (awAddr_ff <= OFS_ENABLE && awAddr_ff[1:0] == 2'h0) ? AXI_OKAY
                                                                          : AXI_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
      if (s_axi_arvalid && !rvalid_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = AXI_OKAY;
         case (s_axi_araddr)
            OFS_LATCH_LO:  nxt_rdata = wideLatch[31:0];
            OFS_LATCH_EXT: nxt_rdata = wideLatch[63:32];
            OFS_MASK_LO:   nxt_rdata = wideMask[31:0];
            OFS_MASK_EXT:  nxt_rdata = wideMask[63:32];
            OFS_BASE_LO:   nxt_rdata = base_ff[31:0];
            OFS_BASE_HI:   nxt_rdata = {16'h0, base_ff[47:32]};
            OFS_SOFT:      nxt_rdata = 32'h0;
            OFS_ACTIVE:    nxt_rdata = {24'h0, state_ff == CIV_SERVICE, 1'b0, num_ff};
            OFS_ENABLE:    nxt_rdata = {31'h0, enable_ff};
            default: begin
               nxt_rdata = 32'h0;
               nxt_rresp = AXI_SLVERR;
            end
         endcase
      end
      if (rvalid_ff && s_axi_rready) nxt_rvalid = 1'b0;
   end
   // register file and latches
   always_comb begin
      logic [63:0] lw, mw;
      lw         = wideLatch;
      mw         = wideMask;
      nxt_mask   = mask_ff;
      nxt_base   = base_ff;
      nxt_enable = enable_ff;
      softSet    = '0;
      if (doWrite) begin
         case (awAddr_ff)
            OFS_LATCH_LO:  lw[31:0]  = lw[31:0] & ~wmerge(32'h0, wData_ff, wStrb_ff);
            OFS_LATCH_EXT: lw[63:32] = lw[63:32] & ~wmerge(32'h0, wData_ff, wStrb_ff);
            OFS_MASK_LO:   mw[31:0]  = wmerge(mw[31:0], wData_ff, wStrb_ff);
            OFS_MASK_EXT:  mw[63:32] = wmerge(mw[63:32], wData_ff, wStrb_ff);
            OFS_BASE_LO:   nxt_base[31:0] = wmerge(base_ff[31:0], wData_ff, wStrb_ff);
            OFS_BASE_HI:   nxt_base[47:32] = 16'(wmerge({16'h0, base_ff[47:32]}, wData_ff,
                                                    wStrb_ff));
            OFS_SOFT: softSet[SRC_SOFT_HI:SRC_SOFT_LO] = wData_ff[3:0] & {4{wStrb_ff[0]}};
            OFS_ENABLE:    nxt_enable = wStrb_ff[0] ? wData_ff[0] : enable_ff;
            default: ;
         endcase
      end
      nxt_mask = mw[41:0];
      nxt_latch = lw[41:0];
      // serviced slot drops on vectoring; arithmetic slots re-latch from live status
      if (branch_ff) nxt_latch[num_ff] = 1'b0;
      // set beats clear
      nxt_latch = nxt_latch | srcVec | softSet;
      nxt_latch[SRC_RESERVED] = 1'b0;
   end

   // vectoring sequence
   always_comb begin
      nxt_state  = state_ff;
      nxt_num    = num_ff;
      nxt_branch = 1'b0;
      nxt_addr   = addr_ff;
      case (state_ff)
         CIV_IDLE: begin
            if (winAny && enable_ff) begin
               nxt_num   = winNum;
               nxt_state = CIV_WAIT_DONE;
            end
         end
         CIV_WAIT_DONE: begin
            if (instrDone) begin
               nxt_branch = 1'b1;
               nxt_addr   = base_ff + {40'h0, num_ff, 2'b00};
               nxt_state  = CIV_SERVICE;
            end
         end
         CIV_SERVICE: begin
            // return alone acks; arithmetic re-raises via live status level
            if (rtiExec) nxt_state = CIV_IDLE;
         end
         default: nxt_state = CIV_IDLE;
      endcase
      nxt_irq = winAny;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         latch_ff  <= '0;
         mask_ff   <= RST_MASK;
         base_ff   <= RST_BASE;
         enable_ff <= 1'b1;
         state_ff  <= CIV_IDLE;
         num_ff    <= 6'h00;
         branch_ff <= 1'b0;
         addr_ff   <= RST_BASE;
         irq_ff    <= 1'b0;
         awHave_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wHave_ff  <= 1'b0;
         wData_ff  <= 32'h0;
         wStrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= AXI_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff  <= AXI_OKAY;
         rdata_ff  <= 32'h0;
      end else begin
         latch_ff  <= nxt_latch;
         mask_ff   <= nxt_mask;
         base_ff   <= nxt_base;
         enable_ff <= nxt_enable;
         state_ff  <= nxt_state;
         num_ff    <= nxt_num;
         branch_ff <= nxt_branch;
         addr_ff   <= nxt_addr;
         irq_ff    <= nxt_irq;
         awHave_ff <= nxt_awHave;
         awAddr_ff <= nxt_awAddr;
         wHave_ff  <= nxt_wHave;
         wData_ff  <= nxt_wData;
         wStrb_ff  <= nxt_wStrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff  <= nxt_rresp;
         rdata_ff  <= nxt_rdata;
      end
   end

   assign vecBranch     = branch_ff;
   assign vecAddr       = addr_ff;
   assign vecNum        = num_ff;
   assign inService     = (state_ff == CIV_SERVICE);
   assign irq           = irq_ff;
   assign s_axi_awready = ~awHave_ff;
   assign s_axi_wready  = ~wHave_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   // checks
   branch_wait_a: assert property (@(posedge clk) disable iff (!rstn)
      state_ff == CIV_WAIT_DONE && instrDone |=> vecBranch && inService)
      else $error("branch not taken after instruction end");
   vec_addr_a: assert property (@(posedge clk) disable iff (!rstn)
      vecBranch |-> vecAddr == $past(base_ff) + {40'h0, vecNum, 2'b00})
      else $error("vector address wrong");
   rti_ends_a: assert property (@(posedge clk) disable iff (!rstn)
      inService && rtiExec |=> state_ff == CIV_IDLE)
      else $error("return did not end service");
   no_early_a: assert property (@(posedge clk) disable iff (!rstn)
      state_ff == CIV_WAIT_DONE && !instrDone |=> !vecBranch)
      else $error("branch before instruction end");
   rti_ack_a: assert property (@(posedge clk) disable iff (!rstn)
      vecBranch && !srcVec[vecNum] && vecNum != SRC_TMR_HIGH |=> !latch_ff[$past(vecNum)])
      else $error("pending not cleared on service");
   arith_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      arith_status[0] |=> latch_ff[SRC_FIX_OVF])
      else $error("arithmetic exception not re-raised");
   prio_fix_a: assert property (@(posedge clk) disable iff (!rstn)
      state_ff == CIV_IDLE && winAny && enable_ff |=> num_ff == $past(winNum)
      && ($past(pendReq) & ~({42{1'b1}} << num_ff)) == 42'h0)
      else $error("priority order broken");
   reserved_a: assert property (@(posedge clk) disable iff (!rstn)
      !latch_ff[SRC_RESERVED])
      else $error("reserved slot raised");
   timer_dual_a: assert property (@(posedge clk) disable iff (!rstn)
      timer_expiry |=> latch_ff[SRC_TMR_HIGH] && latch_ff[SRC_TMR_LOW])
      else $error("timer slots not both raised");
   mask_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      vecBranch |-> mask_ff[vecNum] || $past(mask_ff[vecNum], 2))
      else $error("masked source serviced");
   cov_branch_c: cover property (@(posedge clk) disable iff (!rstn) vecBranch);
   cov_rti_c: cover property (@(posedge clk) disable iff (!rstn) inService && rtiExec);
   cov_arith_c: cover property (@(posedge clk) disable iff (!rstn)
      vecBranch && vecNum == SRC_FIX_OVF);
   cov_write_c: cover property (@(posedge clk) disable iff (!rstn) s_axi_bvalid);
endmodule
`default_nettype wire

// ---- rtl/civ_pkg.sv ----
// Purpose: shared constants for the core interrupt vectoring block
// Assumes: 42 fixed-priority sources, AXI4-Lite register access
// Notes:   byte offsets of the block's own registers are multiples of four
package civ_pkg;
   localparam int          CIV_NSRC      = 42;
   localparam int          CIV_ADDR_W    = 48;
   localparam int          CIV_NUM_W     = 6;
   // source numbers
   localparam logic [5:0]  SRC_EMU_HIGH  = 6'h00;
   localparam logic [5:0]  SRC_RESET     = 6'h01;
   localparam logic [5:0]  SRC_ILLEGAL   = 6'h02;
   localparam logic [5:0]  SRC_STACK_OVF = 6'h03;
   localparam logic [5:0]  SRC_TMR_HIGH  = 6'h04;
   localparam logic [5:0]  SRC_RESERVED  = 6'h07;
   localparam logic [5:0]  SRC_PROG_LO   = 6'h0b;
   localparam logic [5:0]  SRC_PROG_HI   = 6'h1d;
   localparam logic [5:0]  SRC_CB_SEVEN  = 6'h1e;
   localparam logic [5:0]  SRC_CB_FIFTN  = 6'h1f;
   localparam logic [5:0]  SRC_TMR_LOW   = 6'h20;
   localparam logic [5:0]  SRC_FIX_OVF   = 6'h21;
   localparam logic [5:0]  SRC_FLT_INV   = 6'h24;
   localparam logic [5:0]  SRC_EMU_LOW   = 6'h25;
   localparam logic [5:0]  SRC_SOFT_LO   = 6'h26;
   localparam logic [5:0]  SRC_SOFT_HI   = 6'h29;
   // register byte offsets
   localparam logic [7:0]  OFS_LATCH_LO  = 8'h00;
   localparam logic [7:0]  OFS_LATCH_EXT = 8'h04;
   localparam logic [7:0]  OFS_MASK_LO   = 8'h08;
   localparam logic [7:0]  OFS_MASK_EXT  = 8'h0c;
   localparam logic [7:0]  OFS_BASE_LO   = 8'h10;
   localparam logic [7:0]  OFS_BASE_HI   = 8'h14;
   localparam logic [7:0]  OFS_SOFT      = 8'h18;
   localparam logic [7:0]  OFS_ACTIVE    = 8'h1c;
   localparam logic [7:0]  OFS_ENABLE    = 8'h20;
   // reset values, bus response codes and state encoding
   localparam logic [41:0] RST_MASK      = 42'h000_0000_0003;
   localparam logic [47:0] RST_BASE      = 48'h0000_0000_0000;
   localparam logic [1:0]  AXI_OKAY      = 2'h0;
   localparam logic [1:0]  AXI_SLVERR    = 2'h2;
   typedef enum logic [1:0] {CIV_IDLE, CIV_WAIT_DONE, CIV_SERVICE} civ_state_t;
endpackage

// ---- rtl/civ_prio_enc.sv ----
// Purpose: fixed priority pick among unmasked pending sources
// Assumes: lower number wins
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module civ_prio_enc
   import civ_pkg::*;
#(
   parameter int N = 42
) (
   // request vector
   input  wire logic [N-1:0] req,
   // winner
   output logic              any,
   output logic [5:0]        num
);
   always_comb begin
      any = 1'b0;
      num = 6'h00;
      // hard-wired order, no software say in it
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            num = 6'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/civ_seq_model.sv ----
// Purpose: behavioural sequencer on the far side of the vectoring block
// Assumes: one service level, return issued a few cycles after the branch
// Notes:   slowDone spaces instruction completions to stretch the wait
`timescale 1ns/1ps
`default_nettype none
module civ_seq_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // bench control
   input  wire logic slowDone,
   input  wire logic holdRti,
   // design side
   input  wire logic vecBranch,
   input  wire logic inService,
   output logic      instrDone,
   output logic      rtiExec
);
   logic [2:0] phase_ff;
   logic [3:0] svc_ff;
   // completion either every cycle or one in eight
   assign instrDone = slowDone ? (phase_ff == 3'h4) : 1'b1;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_ff <= 3'h0;
         svc_ff   <= 4'h0;
         rtiExec  <= 1'b0;
      end else begin
         phase_ff <= phase_ff + 3'h1;
         rtiExec  <= 1'b0;
         // return only while the block says a routine runs
         if (vecBranch) begin
            svc_ff <= 4'h6;
         end else if (svc_ff > 4'h1) begin
            svc_ff <= svc_ff - 4'h1;
         end else if (svc_ff == 4'h1 && !holdRti && inService) begin
            svc_ff  <= 4'h0;
            rtiExec <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/test_core_interrupt_vectoring.sv ----
// Purpose: self-checking bench for the core interrupt vectoring block
// Assumes: sequencer model on the far side, AXI4-Lite master tasks here
// Notes:   arith_status bit0 is taken as the fixed-point overflow
`timescale 1ns/1ps
`default_nettype none
module test_core_interrupt_vectoring
   import civ_pkg::*;
;
   localparam logic [47:0] BASE = 48'h0012_3456_7800;
   typedef struct packed {logic [5:0] src; logic [5:0] num;} civ_row_t;
   logic        clk = 1'b0, rstn = 1'b0, slowDone = 1'b1, holdRti = 1'b0, prevDone = 1'b0;
   logic [41:0] evt = '0;
   logic [3:0]  arith = '0;
   logic        instrDone, rtiExec, vecBranch, inService, irq;
   logic [47:0] vecAddr;
   logic [5:0]  vecNum;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   int          err_count = 0, compares = 0;
   civ_row_t    rows [15] = '{'{6'h00, 6'h00}, '{6'h01, 6'h01},
      '{6'h02, 6'h02}, '{6'h03, 6'h03},
      '{6'h05, 6'h05}, '{6'h06, 6'h06}, '{6'h08, 6'h08}, '{6'h09, 6'h09}, '{6'h0a, 6'h0a},
      '{6'h0b, 6'h0b}, '{6'h14, 6'h14}, '{6'h1d, 6'h1d},
      '{6'h1e, 6'h1e}, '{6'h1f, 6'h1f}, '{6'h25, 6'h25}};

   always #50 clk = ~clk;
   always @(posedge clk) prevDone <= instrDone;

   civ_core u_dut (.clk(clk), .rstn(rstn), .emulator_high_irq(evt[0]), .reset_irq(evt[1]),
      .illegal_access_irq(evt[2]), .stack_overflow_irq(evt[3]), .timer_expiry(evt[4]),
      .serial_port_error_irq(evt[5]), .hardware_breakpoint_irq(evt[6]),
      .external_request_irq({evt[8], evt[9], evt[10]}), .programmable_irq(evt[29:11]),
      .circ_buf_seven_irq(evt[30]), .circ_buf_fifteen_irq(evt[31]), .arith_status(arith),
      .emulator_low_irq(evt[37]), .instrDone(instrDone), .rtiExec(rtiExec),
      .vecBranch(vecBranch), .vecAddr(vecAddr), .vecNum(vecNum), .inService(inService),
      .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   civ_seq_model u_seq (.clk(clk), .rstn(rstn), .slowDone(slowDone), .holdRti(holdRti),
      .vecBranch(vecBranch), .inService(inService), .instrDone(instrDone), .rtiExec(rtiExec));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // an edge passes first so no handshake signal is set twice in one step
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, rsp);
      check("bresp", rsp, AXI_OKAY);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, rd, rsp);
      check("rresp", rsp, AXI_OKAY);
      check(what, rd, e);
   endtask
   task automatic expect_vec(input logic [5:0] num);
      // no local limit: a branch that never comes is left to the watchdog
      do begin
         @(posedge clk);
      end while (vecBranch !== 1'b1);
      check("vecNum", vecNum, num);
      check("vecAddr", vecAddr, BASE + {40'h0, num, 2'b00});
      check("doneBefore", prevDone, 1'b1);
      check("inService", inService, 1'b1);
   endtask
   task automatic no_vec(input int cyc);
      logic seen;
      seen = 1'b0;
      repeat (cyc) begin
         @(posedge clk);
         if (vecBranch !== 1'b0) seen = 1'b1;
      end
      check("noBranch", seen, 1'b0);
   endtask
   task automatic wait_idle();
      while (inService !== 1'b0) begin
         @(posedge clk);
      end
   endtask
   task automatic test_end(input string s);
      $display("test %s done, %0d mismatches so far", s, err_count);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rdchk("maskLo", OFS_MASK_LO, 32'h0000_0003);
      rdchk("enable", OFS_ENABLE, 32'h0000_0001);
      rdchk("status", OFS_ACTIVE, 32'h0000_0000);
      wr(OFS_MASK_LO, 32'hffff_ffff);
      wr(OFS_MASK_EXT, 32'h0000_03ff);
      wr(OFS_BASE_LO, 32'h3456_7800);
      wr(OFS_BASE_HI, 32'h0000_0012);
      rdchk("baseHi", OFS_BASE_HI, 32'h0000_0012);
      axi_rd(8'h40, rd, rsp);
      check("unmappedResp", {rsp, rd}, {AXI_SLVERR, 32'h0});
      axi_wr(8'h02, 32'h0000_0001, rsp);
      check("unalignedResp", rsp, AXI_SLVERR);
      test_end("registers");
      foreach (rows[i]) begin
         wait_idle();
         evt[rows[i].src] <= 1'b1;
         @(posedge clk);
         evt <= '0;
         expect_vec(rows[i].num);
      end
      test_end("table");
      // priority, masking and the global enable
      slowDone <= 1'b0;
      wait_idle();
      wr(OFS_ENABLE, 32'h0000_0000);
      wr(OFS_MASK_LO, 32'hffef_ffff);
      evt[5] <= 1'b1;
      evt[20] <= 1'b1;
      evt[37] <= 1'b1;
      @(posedge clk);
      evt <= '0;
      wr(OFS_SOFT, 32'h0000_0009);
      rdchk("latchLo", OFS_LATCH_LO, 32'h0010_0020);
      rdchk("latchExt", OFS_LATCH_EXT, 32'h0000_0260);
      rdchk("soft", OFS_SOFT, 32'h0000_0000);
      check("irqPending", irq, 1'b1);
      no_vec(10);
      wr(OFS_ENABLE, 32'h0000_0001);
      expect_vec(SRC_EMU_HIGH + 6'h05);
      expect_vec(SRC_EMU_LOW);
      expect_vec(SRC_SOFT_LO);
      expect_vec(SRC_SOFT_HI);
      no_vec(30);
      check("irqMasked", irq, 1'b0);
      wr(OFS_LATCH_LO, 32'h0010_0000);
      rdchk("latchClr", OFS_LATCH_LO, 32'h0000_0000);
      wr(OFS_MASK_LO, 32'hffff_ffff);
      test_end("priority");
      evt[4] <= 1'b1;
      @(posedge clk);
      evt <= '0;
      expect_vec(SRC_TMR_HIGH);
      expect_vec(SRC_TMR_LOW);
      no_vec(30);
      test_end("timer");
      // arithmetic exception keeps coming back until its status is cleared
      holdRti <= 1'b1;
      arith <= 4'h1;
      expect_vec(SRC_FIX_OVF);
      rdchk("status", OFS_ACTIVE, 32'h0000_00a1);
      holdRti <= 1'b0;
      expect_vec(SRC_FIX_OVF);
      holdRti <= 1'b1;
      rdchk("latchExt", OFS_LATCH_EXT, 32'h0000_0002);
      arith <= 4'h0;
      wr(OFS_LATCH_EXT, 32'h0000_0002);
      holdRti <= 1'b0;
      no_vec(40);
      // idle, but the last serviced number stays readable
      rdchk("statusIdle", OFS_ACTIVE, 32'h0000_0021);
      test_end("arithmetic");
      // second reset in mid-run restores the defaults
      rstn <= 1'b0;
      @(posedge clk);
      check("rstOut", {vecBranch, inService, irq, awready}, 4'h1);
      rstn <= 1'b1;
      rdchk("baseLo", OFS_BASE_LO, 32'h0000_0000);
      evt[6] <= 1'b1;
      @(posedge clk);
      evt <= '0;
      no_vec(20);
      check("irqRst", irq, 1'b0);
      test_end("reset");
      report_and_stop();
   end
endmodule
`default_nettype wire
